// *** mcpe_encoder.sv ***
`timescale 1ns/1ps
// What this block does
// - each packet spans four link clocks, one slot per edge, eight slots
// - row packets hold 24 bits, column packets hold 40 bits
// - row packets drive request wires 7 down to 5
// - column packets drive request wires 4 down to 0
// - rows are activated only by row packets, accepted in any active state
// - a non-broadcast row packet makes its addressed device active unless it is a sleep-type command, which parks it
// - a row packet normally goes to a device before any column packet
// - select pair: 00 none, 01 id4 low, 10 id4 high, 11 broadcast
// - cycle 0 holds select pair and device id, cycle 1 bank and reserved
// - cycles 2-3 hold row address or row opcode chosen by select bit
// - precharge, precharge-relax, refresh, post-refresh precharge opcodes
// - nap, conditional nap, power-down, relax, temp-cal and no-op opcodes
// - fixed packet positions are driven exactly, don't-cares either way
// - read and write go only through column packets to active devices
// - a column packet to a device that is not active is refused, not held
// - column packet carries device id, opcode, bank and column address
// - start bit on wire 4 of slot 1, opcode bits 1,0,2 below it
// - start 0 no-op; 000 retire buffer, 001 write, 011 read
// - only no-op, retire, write and read column codes are ever sent
// - mask-format bit 1 carries two byte masks, 0 the extra form
// - extra form: device id, extra opcode and bank after the format bit
// - extra opcodes: none, calibrate, calibrate and sample only
module mcpe_encoder
	import mcpe_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// memory clock from the channel
	input wire logic mem_clk,
	// row request
	input wire logic row_req,
	input wire logic [4:0] row_device_id,
	input wire logic row_broadcast,
	input wire logic [4:0] row_bank_addr,
	input wire mcpe_row_op_type row_cmd,
	input wire logic [10:0] row_addr,
	output logic row_ack,
	// column request
	input wire logic col_req,
	input wire logic [4:0] col_device_id,
	input wire mcpe_col_cmd_type col_cmd,
	input wire logic [4:0] col_bank_addr,
	input wire logic [6:0] col_addr,
	input wire logic col_mask_fmt,
	input wire logic [7:0] byte_mask_low,
	input wire logic [7:0] byte_mask_high,
	input wire logic [4:0] extra_device_id,
	input wire mcpe_xop_type extra_op,
	input wire logic [4:0] extra_bank_addr,
	output logic col_ack,
	output logic col_refused,
	// status
	output logic [31:0] dev_active,
	output logic row_busy,
	output logic col_busy,
	// channel request wires
	output logic [7:0] request_wires
);

	// ------------------------------------------------------------
	// link clock synchroniser and edge finder
	// ------------------------------------------------------------
	logic link_sync1_reg;
	logic link_sync2_reg;
	logic link_prev_reg;
	logic rise_hit;
	logic fall_hit;
	logic edge_hit;

	// two flops before any logic looks at the memory clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link_sync1_reg <= 1'b0;
			link_sync2_reg <= 1'b0;
			link_prev_reg <= 1'b0;
		end else begin
			link_sync1_reg <= mem_clk;
			link_sync2_reg <= link_sync1_reg;
			link_prev_reg <= link_sync2_reg;
		end
	end

	// both edges carry data, rising edge opens a packet
	assign rise_hit = link_sync2_reg && !link_prev_reg;
	assign fall_hit = !link_sync2_reg && link_prev_reg;
	assign edge_hit = rise_hit || fall_hit;

	// ------------------------------------------------------------
	// row packet assembly
	// ------------------------------------------------------------
	logic [1:0] sel_pair;
	logic activate_select;
	logic [10:0] row_opcode;
	logic [10:0] row_field;
	logic [ROW_BITS-1:0] row_packet;
	logic row_sleep;

	// opcode table; activate leaves opcode unused
	assign row_opcode = (row_cmd == ROW_PRECHARGE) ? RCODE_PRECHARGE :
		(row_cmd == ROW_PRE_RELAX) ? RCODE_PRE_RELAX :
		(row_cmd == ROW_REFRESH) ? RCODE_REFRESH :
		(row_cmd == ROW_PRE_POSTREF) ? RCODE_PRE_POSTREF :
		(row_cmd == ROW_NAP) ? RCODE_NAP :
		(row_cmd == ROW_COND_NAP) ? RCODE_COND_NAP :
		(row_cmd == ROW_POWER_DOWN) ? RCODE_POWER_DOWN :
		(row_cmd == ROW_RELAX) ? RCODE_RELAX :
		(row_cmd == ROW_TCAL_ENABLE) ? RCODE_TCAL_ENABLE :
		(row_cmd == ROW_TCAL) ? RCODE_TCAL : RCODE_NOOP;

	// the only path to sensing a row is this select bit
	assign activate_select = (row_cmd == ROW_ACTIVATE);
	assign row_field = activate_select ? row_addr : row_opcode;

	// select pair carries id bit 4 unless broadcasting
	assign sel_pair = row_broadcast ? SEL_BROADCAST :
		(row_device_id[4] ? SEL_ID4_HIGH : SEL_ID4_LOW);

	// slot 0 first; every position fixed, so no don't-care is left open
	assign row_packet = {
		sel_pair, row_device_id[3],
		row_device_id[2], row_device_id[1], row_device_id[0],
		row_bank_addr[0], row_bank_addr[1], row_bank_addr[2],
		row_bank_addr[3], row_bank_addr[4], RESERVED_LEVEL,
		row_field[10], row_field[9], activate_select,
		row_field[8], row_field[7], row_field[6],
		row_field[5:0]
	};

	// commands that leave the device outside the active state
	assign row_sleep = (row_cmd == ROW_NAP) || (row_cmd == ROW_COND_NAP) ||
		(row_cmd == ROW_POWER_DOWN) || (row_cmd == ROW_RELAX) ||
		(row_cmd == ROW_PRE_RELAX);

	// ------------------------------------------------------------
	// column packet assembly
	// ------------------------------------------------------------
	logic col_start;
	logic [3:0] col_opcode;
	logic [4:0] extra_code;
	logic [15:0] mask_bits;
	logic [4:0] col_slot2;
	logic [4:0] col_slot3;
	logic [4:0] col_slot4;
	logic [4:0] col_slot5;
	logic [COL_BITS-1:0] col_packet;

	// only the four legal codes can be formed; bit 3 driven low
	assign col_start = (col_cmd != COL_NOP);
	assign col_opcode = (col_cmd == COL_WRITE) ? CCODE_WRITE :
		(col_cmd == COL_READ) ? CCODE_READ : CCODE_RETIRE;

	// reserved extra codes have no input value that reaches them
	assign extra_code = (extra_op == XOP_CAL) ? XOP_CODE_CAL :
		(extra_op == XOP_CAL_SAMPLE) ? XOP_CODE_CAL_SAMPLE : XOP_CODE_NONE;

	// mask form fills the sixteen positions the extra form uses
	assign mask_bits = {byte_mask_low, byte_mask_high};
	assign col_slot2 = col_mask_fmt ? mask_bits[15:11] : extra_device_id;
	assign col_slot3 = col_mask_fmt ? mask_bits[10:6] : extra_code;
	assign col_slot4 = col_mask_fmt ? {mask_bits[5:2], col_opcode[3]} :
		{RESERVED_LEVEL, extra_bank_addr[4:2], col_opcode[3]};
	assign col_slot5 = col_mask_fmt ?
		{mask_bits[1:0], RESERVED_LEVEL, col_bank_addr[4:3]} :
		{extra_bank_addr[1:0], RESERVED_LEVEL, col_bank_addr[4:3]};

	// slot 0 device id, slot 1 start, format and opcode
	assign col_packet = {
		col_device_id,
		col_start, col_mask_fmt, col_opcode[1], col_opcode[0], col_opcode[2],
		col_slot2,
		col_slot3,
		col_slot4,
		col_slot5,
		col_addr[6], col_addr[5], col_bank_addr[2:0],
		col_addr[4:0]
	};

	// ------------------------------------------------------------
	// device state tracking and request gating
	// ------------------------------------------------------------
	logic [31:0] dev_active_reg;
	logic [31:0] dev_active_next;
	logic [31:0] dev_onehot;
	logic row_can_start;
	logic col_can_start;
	logic col_target_ok;

	assign dev_onehot = 32'h0000_0001 << row_device_id;

	// any addressed row wakes its device; sleep-type commands park it
	always_comb begin
		dev_active_next = dev_active_reg;
		if (row_ack) begin
			if (row_broadcast) begin
				if (row_sleep) begin
					dev_active_next = DEV_ACTIVE_RESET;
				end
			end else if (row_sleep) begin
				dev_active_next = dev_active_reg & ~dev_onehot;
			end else begin
				dev_active_next = dev_active_reg | dev_onehot;
			end
		end
	end

	// all devices start in standby, so a row must come first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dev_active_reg <= DEV_ACTIVE_RESET;
		end else begin
			dev_active_reg <= dev_active_next;
		end
	end

	// rows go out whatever the device state; columns need an active target
	assign col_target_ok = dev_active_reg[col_device_id];
	assign row_ack = row_can_start && row_req;
	assign col_ack = col_can_start && col_req && col_target_ok;
	assign col_refused = col_can_start && col_req && !col_target_ok;
	assign dev_active = dev_active_reg;

	// ------------------------------------------------------------
	// lane serializers
	// ------------------------------------------------------------
	logic [ROW_WIRES-1:0] row_wires;
	logic [COL_WIRES-1:0] col_wires;

	mcpe_lane_serializer #(
		.WIDTH(ROW_WIRES)
	) u_row_lane (
		.clk(clk),
		.nrst(nrst),
		.edge_hit(edge_hit),
		.rise_hit(rise_hit),
		.load(row_req),
		.packet(row_packet),
		.wires(row_wires),
		.busy(row_busy),
		.can_start(row_can_start)
	);

	mcpe_lane_serializer #(
		.WIDTH(COL_WIRES)
	) u_col_lane (
		.clk(clk),
		.nrst(nrst),
		.edge_hit(edge_hit),
		.rise_hit(rise_hit),
		.load(col_ack),
		.packet(col_packet),
		.wires(col_wires),
		.busy(col_busy),
		.can_start(col_can_start)
	);

	// upper wires carry rows, lower wires carry columns
	assign request_wires = {row_wires, col_wires};

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [3:0] row_edge_cnt_reg;

	// counts link edges of the current row packet, for the length check
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			row_edge_cnt_reg <= EDGE_CNT_RESET;
		end else if (row_ack) begin
			row_edge_cnt_reg <= EDGE_CNT_RESET;
		end else if (edge_hit && row_busy) begin
			row_edge_cnt_reg <= row_edge_cnt_reg + 4'h1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence row_taken_s;
		row_ack && rise_hit;
	endsequence

	sequence row_slot0_s;
		##1 request_wires[7:5] == $past(row_packet[23:21]);
	endsequence

	row_length_a: assert property ($fell(row_busy) |-> row_edge_cnt_reg == EDGE_CNT_DONE)
		else $error("row packet did not span eight link edges");
	row_first_slot_a: assert property (row_taken_s |-> row_slot0_s)
		else $error("row slot 0 does not carry select pair and id bit 3");
	row_idle_a: assert property (!row_busy |-> request_wires[7:5] == 3'h0)
		else $error("row wires not idle low");
	col_idle_a: assert property (!col_busy |-> request_wires[4:0] == 5'h00)
		else $error("column wires not idle low");
	col_gate_a: assert property (col_ack |-> dev_active_reg[col_device_id] && !col_refused)
		else $error("column packet sent to a device that is not active");
	col_dev_slot_a: assert property (col_ack |=> request_wires[4:0] == $past(col_device_id))
		else $error("column slot 0 does not carry the device id");
	row_wake_a: assert property (row_ack && !row_broadcast && !row_sleep
		|=> dev_active_reg[$past(row_device_id)])
		else $error("addressed row did not make its device active");
	col_code_a: assert property (col_ack && col_packet[34]
		|-> col_packet[32:30] inside {3'h0, 3'h2, 3'h6})
		else $error("reserved column opcode formed");
	extra_form_a: assert property (col_ack && !col_mask_fmt
		|-> !col_packet[33] && col_packet[29:25] == extra_device_id)
		else $error("extra form layout wrong");
	row_select_a: assert property (row_ack |-> row_packet[9] == (row_cmd == ROW_ACTIVATE))
		else $error("row select bit does not match the command");

endmodule

// *** mcpe_pkg.sv ***
package mcpe_pkg;

	// ------------------------------------------------------------
	// packet geometry
	// ------------------------------------------------------------
	localparam int SLOT_COUNT = 8;
	localparam int ROW_WIRES = 3;
	localparam int COL_WIRES = 5;
	localparam int ROW_BITS = 24;
	localparam int COL_BITS = 40;
	localparam int DEV_COUNT = 32;
	localparam logic [2:0] SLOT_IDLE = 3'h0;
	localparam logic [2:0] SLOT_ONE = 3'h1;

	// ------------------------------------------------------------
	// reset values and fixed levels
	// ------------------------------------------------------------
	localparam logic [31:0] DEV_ACTIVE_RESET = 32'h0000_0000;
	localparam logic RESERVED_LEVEL = 1'b0;
	localparam logic [3:0] EDGE_CNT_RESET = 4'h0;
	localparam logic [3:0] EDGE_CNT_DONE = 4'h8;

	// ------------------------------------------------------------
	// row device select pair
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_ID4_LOW = 2'h1;
	localparam logic [1:0] SEL_ID4_HIGH = 2'h2;
	localparam logic [1:0] SEL_BROADCAST = 2'h3;

	// ------------------------------------------------------------
	// row commands and their 11-bit opcodes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ROW_ACTIVATE = 4'h0,
		ROW_PRECHARGE = 4'h1,
		ROW_PRE_RELAX = 4'h2,
		ROW_REFRESH = 4'h3,
		ROW_PRE_POSTREF = 4'h4,
		ROW_NAP = 4'h5,
		ROW_COND_NAP = 4'h6,
		ROW_POWER_DOWN = 4'h7,
		ROW_RELAX = 4'h8,
		ROW_TCAL_ENABLE = 4'h9,
		ROW_TCAL = 4'hA,
		ROW_NOOP = 4'hB
	} mcpe_row_op_type;

	localparam logic [10:0] RCODE_PRECHARGE = 11'h600;
	localparam logic [10:0] RCODE_PRE_RELAX = 11'h608;
	localparam logic [10:0] RCODE_REFRESH = 11'h0C0;
	localparam logic [10:0] RCODE_PRE_POSTREF = 11'h540;
	localparam logic [10:0] RCODE_NAP = 11'h020;
	localparam logic [10:0] RCODE_COND_NAP = 11'h030;
	localparam logic [10:0] RCODE_POWER_DOWN = 11'h010;
	localparam logic [10:0] RCODE_RELAX = 11'h008;
	localparam logic [10:0] RCODE_TCAL_ENABLE = 11'h002;
	localparam logic [10:0] RCODE_TCAL = 11'h001;
	localparam logic [10:0] RCODE_NOOP = 11'h000;

	// ------------------------------------------------------------
	// column commands, opcodes and extra opcodes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		COL_NOP = 2'h0,
		COL_RETIRE = 2'h1,
		COL_WRITE = 2'h2,
		COL_READ = 2'h3
	} mcpe_col_cmd_type;

	localparam logic [3:0] CCODE_RETIRE = 4'h0;
	localparam logic [3:0] CCODE_WRITE = 4'h1;
	localparam logic [3:0] CCODE_READ = 4'h3;

	typedef enum logic [1:0] {
		XOP_NONE = 2'h0,
		XOP_CAL = 2'h1,
		XOP_CAL_SAMPLE = 2'h2
	} mcpe_xop_type;

	localparam logic [4:0] XOP_CODE_NONE = 5'h00;
	localparam logic [4:0] XOP_CODE_CAL = 5'h08;
	localparam logic [4:0] XOP_CODE_CAL_SAMPLE = 5'h0C;

endpackage

// *** mcpe_lane_serializer.sv ***
`timescale 1ns/1ps
module mcpe_lane_serializer
	import mcpe_pkg::*;
#(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// link clock edges, already synchronised
	input wire logic edge_hit,
	input wire logic rise_hit,
	// packet offered by the scheduler
	input wire logic load,
	input wire logic [WIDTH*SLOT_COUNT-1:0] packet,
	// lane outputs
	output logic [WIDTH-1:0] wires,
	output logic busy,
	output logic can_start
);

	// ------------------------------------------------------------
	// slot bookkeeping
	// ------------------------------------------------------------
	logic [2:0] slot_reg;
	logic [WIDTH*SLOT_COUNT-1:0] packet_reg;
	logic [WIDTH-1:0] wires_reg;
	logic busy_reg;
	logic running;
	logic [WIDTH-1:0] first_slot;
	logic [WIDTH-1:0] next_slot;

	// slot 0 sits in the top bits of the packet vector
	assign running = (slot_reg != SLOT_IDLE);
	assign can_start = rise_hit && !running;
	assign first_slot = packet[WIDTH*SLOT_COUNT-1 -: WIDTH];
	assign next_slot = packet_reg[(SLOT_COUNT - 1 - int'(slot_reg)) * WIDTH +: WIDTH];
	assign wires = wires_reg;
	assign busy = busy_reg;

	// one slot per link edge; a new packet only starts on a rising edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slot_reg <= SLOT_IDLE;
			packet_reg <= '0;
			wires_reg <= '0;
			busy_reg <= 1'b0;
		end else if (edge_hit) begin
			if (running) begin
				wires_reg <= next_slot;
				slot_reg <= slot_reg + SLOT_ONE;
			end else if (can_start && load) begin
				wires_reg <= first_slot;
				packet_reg <= packet;
				slot_reg <= SLOT_ONE;
				busy_reg <= 1'b1;
			end else begin
				wires_reg <= '0; // idle lane reads as no packet
				busy_reg <= 1'b0;
			end
		end
	end

endmodule

// *** mcpe_device_model.sv ***
`timescale 1ns/1ps
module mcpe_device_model
	import mcpe_pkg::*;
(
	// link clock made by the channel
	output logic mem_clk,
	// packet lanes and frame qualifiers
	input wire logic [7:0] request_wires,
	input wire logic row_busy,
	input wire logic col_busy
);
	// ------------------------------------------------------------
	// captured packets and device state
	// ------------------------------------------------------------
	logic [23:0] row_pkt;
	logic [39:0] col_pkt;
	logic [23:0] row_q[$];
	logic [39:0] col_q[$];
	logic [31:0] active;
	logic [2:0] lc;
	logic [4:0] xo;
	int row_n;
	int col_n;
	int viol;

	// free running link clock, phase unrelated to the system clock
	initial begin
		active = 32'h0;
		row_n = 0;
		col_n = 0;
		viol = 0;
		mem_clk = 1'h0;
		#13;
		forever #200 mem_clk = ~mem_clk;
	end

	// a slot is settled 100 ns after the link edge that follows its own
	always @(mem_clk) begin
		#100;
		if (row_busy) begin
			row_pkt = {row_pkt[20:0], request_wires[7:5]};
			row_n++;
		end else
			row_n = 0;
		if (col_busy) begin
			col_pkt = {col_pkt[34:0], request_wires[4:0]};
			col_n++;
		end else
			col_n = 0;
		// row packet: broadcast nap-type clears all, addressed one wakes or parks
		if (row_n == 8) begin
			row_n = 0;
			row_q.push_back(row_pkt);
			if (row_pkt[23:22] == SEL_NONE)
				viol++;
			else if (row_pkt[23:22] == SEL_BROADCAST) begin
				if (!row_pkt[9] && |row_pkt[5:3])
					active = 32'h0;
			end else
				active[{row_pkt[23], row_pkt[21:18]}] = row_pkt[9] | ~|row_pkt[5:3];
		end
		// column packet: only active targets, only legal codes
		if (col_n == 8) begin
			col_n = 0;
			col_q.push_back(col_pkt);
			lc = {col_pkt[30], col_pkt[32], col_pkt[31]};
			xo = col_pkt[24:20];
			if (!active[col_pkt[39:35]])
				viol++;
			if (col_pkt[34] && !(lc == 3'h0 || lc == 3'h1 || lc == 3'h3))
				viol++;
			if (!col_pkt[33] && !(xo == 5'h00 || xo == 5'h08 || xo == 5'h0C))
				viol++;
		end
	end
endmodule

// *** tb_memory_command_packet_encoder.sv ***
`timescale 1ns/1ps
module tb_memory_command_packet_encoder
	import mcpe_pkg::*;
;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic clk, nrst, mem_clk, row_req, row_broadcast, row_ack, col_req, col_mask_fmt;
	logic col_ack, col_refused, row_busy, col_busy;
	logic [4:0] row_device_id, row_bank_addr, col_device_id, col_bank_addr;
	logic [4:0] extra_device_id, extra_bank_addr;
	logic [10:0] row_addr;
	logic [6:0] col_addr;
	logic [7:0] byte_mask_low, byte_mask_high, request_wires;
	logic [31:0] dev_active;
	mcpe_row_op_type row_cmd;
	mcpe_col_cmd_type col_cmd;
	mcpe_xop_type extra_op;
	logic [23:0] exp_row[$];
	logic [39:0] exp_col[$];
	int n_mismatch = 0;
	int num_checks = 0;

	mcpe_encoder dut (.clk(clk), .nrst(nrst), .mem_clk(mem_clk), .row_req(row_req),
		.row_device_id(row_device_id), .row_broadcast(row_broadcast),
		.row_bank_addr(row_bank_addr), .row_cmd(row_cmd), .row_addr(row_addr),
		.row_ack(row_ack), .col_req(col_req), .col_device_id(col_device_id),
		.col_cmd(col_cmd), .col_bank_addr(col_bank_addr), .col_addr(col_addr),
		.col_mask_fmt(col_mask_fmt), .byte_mask_low(byte_mask_low),
		.byte_mask_high(byte_mask_high), .extra_device_id(extra_device_id),
		.extra_op(extra_op), .extra_bank_addr(extra_bank_addr), .col_ack(col_ack),
		.col_refused(col_refused), .dev_active(dev_active), .row_busy(row_busy),
		.col_busy(col_busy), .request_wires(request_wires));

	mcpe_device_model model (.mem_clk(mem_clk), .request_wires(request_wires),
		.row_busy(row_busy), .col_busy(col_busy));

	// system clock, 50 ns period
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// ------------------------------------------------------------
	// comparison, request and flush tasks
	// ------------------------------------------------------------
	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// row field as {f[10:0], select}, written out bit by bit from the encodings
	function automatic logic [11:0] exp_field(mcpe_row_op_type c, logic [10:0] ra);
		case (c)
			ROW_ACTIVATE: return {ra, 1'h1};
			ROW_PRECHARGE: return {11'h600, 1'h0};
			ROW_PRE_RELAX: return {11'h608, 1'h0};
			ROW_REFRESH: return {11'h0C0, 1'h0};
			ROW_PRE_POSTREF: return {11'h540, 1'h0};
			ROW_NAP: return {11'h020, 1'h0};
			ROW_COND_NAP: return {11'h030, 1'h0};
			ROW_POWER_DOWN: return {11'h010, 1'h0};
			ROW_RELAX: return {11'h008, 1'h0};
			ROW_TCAL_ENABLE: return {11'h002, 1'h0};
			ROW_TCAL: return {11'h001, 1'h0};
			default: return 12'h000;
		endcase
	endfunction

	task automatic row_op(input logic [4:0] id, input logic bc, input logic [4:0] bk,
		input mcpe_row_op_type cmd, input logic [10:0] ra);
		logic [11:0] fl;
		logic [1:0] sel;
		int n;
		fl = exp_field(cmd, ra);
		sel = bc ? 2'h3 : (id[4] ? 2'h2 : 2'h1);
		@(posedge clk) #2;
		row_device_id = id;
		row_broadcast = bc;
		row_bank_addr = bk;
		row_cmd = cmd;
		row_addr = ra;
		row_req = 1'h1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (row_ack !== 1'h1 && n < 200);
		check(40'(n < 200), 40'h1, "row request not taken");
		@(posedge clk) #2;
		row_req = 1'h0;
		exp_row.push_back({sel, id[3:0], bk[0], bk[1], bk[2], bk[3], bk[4], 1'h0,
			fl[11:10], fl[0], fl[9:1]});
	endtask

	// fixed bank, address and masks keep the argument list short
	task automatic col_op(input logic [4:0] dv, input mcpe_col_cmd_type c, input logic m,
		input mcpe_xop_type xo, input logic rf);
		logic [2:0] opc;
		logic [4:0] xop;
		logic [19:0] mid;
		int n;
		opc = (c == COL_READ) ? 3'h3 : ((c == COL_WRITE) ? 3'h1 : 3'h0);
		xop = (xo == XOP_CAL) ? 5'h08 : ((xo == XOP_CAL_SAMPLE) ? 5'h0C : 5'h00);
		mid = m ? {8'hC3, 6'h16, 1'h0, 2'h2, 1'h0, 2'h2}
			: {5'h09, xop, 1'h0, 3'h7, 1'h0, 2'h1, 1'h0, 2'h2};
		@(posedge clk) #2;
		col_device_id = dv;
		col_cmd = c;
		col_bank_addr = 5'h16;
		col_addr = 7'h4B;
		col_mask_fmt = m;
		byte_mask_low = 8'hC3;
		byte_mask_high = 8'h5A;
		extra_device_id = 5'h09;
		extra_op = xo;
		extra_bank_addr = 5'h1D;
		col_req = 1'h1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (col_ack !== 1'h1 && col_refused !== 1'h1 && n < 200);
		check(40'(n < 200), 40'h1, "column request not answered");
		check(40'(col_refused), 40'(rf), "column refusal");
		@(posedge clk) #2;
		col_req = 1'h0;
		// column address 4B splits as c6..c5 = 2, c4..c0 = 0B; bank 16 low bits = 6
		if (!rf)
			exp_col.push_back({dv, c != COL_NOP, m, opc[1], opc[0], opc[2], mid,
				2'h2, 3'h6, 5'h0B});
	endtask

	task automatic flush();
		int n;
		n = 0;
		while ((model.row_q.size() < exp_row.size() || model.col_q.size() < exp_col.size())
			&& n < 4000) begin
			@(posedge clk) #2;
			n++;
		end
		while (!(row_busy === 1'h0 && col_busy === 1'h0) && n < 4000) begin
			@(posedge clk) #2;
			n++;
		end
		check(40'(n < 4000), 40'h1, "lanes did not drain");
		check(40'(model.row_q.size()), 40'(exp_row.size()), "row packet count");
		check(40'(model.col_q.size()), 40'(exp_col.size()), "column packet count");
		while (exp_row.size() > 0 && model.row_q.size() > 0)
			check(40'(model.row_q.pop_front()), 40'(exp_row.pop_front()), "row packet");
		while (exp_col.size() > 0 && model.col_q.size() > 0)
			check(model.col_q.pop_front(), exp_col.pop_front(), "column packet");
		exp_row.delete();
		exp_col.delete();
		check(40'(request_wires), 40'h0, "idle request wires");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		{nrst, row_req, row_broadcast, col_req, col_mask_fmt} = 5'h00;
		{row_device_id, row_bank_addr, col_device_id, col_bank_addr} = 20'h00000;
		{extra_device_id, extra_bank_addr, row_addr, col_addr} = 28'h0000000;
		{byte_mask_low, byte_mask_high} = 16'h0000;
		row_cmd = ROW_NOOP;
		col_cmd = COL_NOP;
		extra_op = XOP_NONE;
		repeat (16) @(posedge clk);
		#2 nrst = 1'h1;
		repeat (4) @(posedge clk);
		#2;
		check(40'(request_wires), 40'h0, "wires after reset");
		check(40'(dev_active), 40'h0, "devices after reset");
		col_op(5'h03, COL_READ, 1'h1, XOP_NONE, 1'h1);
		row_op(5'h03, 1'h0, 5'h15, ROW_ACTIVATE, 11'h5A3);
		flush();
		check(40'(dev_active[3]), 40'h1, "addressed device active");
		// both lanes at once, then every column code and form
		fork
			row_op(5'h03, 1'h0, 5'h0A, ROW_REFRESH, 11'h000);
			col_op(5'h03, COL_READ, 1'h1, XOP_NONE, 1'h0);
		join
		for (int i = 0; i < 4; i++)
			col_op(5'h03, mcpe_col_cmd_type'(i), 1'h1, XOP_NONE, 1'h0);
		for (int i = 0; i < 3; i++)
			col_op(5'h03, COL_WRITE, 1'h0, mcpe_xop_type'(i), 1'h0);
		flush();
		// every row command back to back, id bit 4 high
		for (int i = 0; i < 12; i++)
			row_op(5'h13, 1'h0, 5'(i), mcpe_row_op_type'(i), 11'h2C5);
		// a broadcast that is not a sleep command must leave device states alone
		row_op(5'h00, 1'h1, 5'h1F, ROW_REFRESH, 11'h000);
		flush();
		check(40'(dev_active[19]), 40'h1, "device after no-op row");
		row_op(5'h00, 1'h1, 5'h1F, ROW_NAP, 11'h000);
		flush();
		check(40'(dev_active), 40'h0, "broadcast nap parks all");
		col_op(5'h03, COL_WRITE, 1'h1, XOP_NONE, 1'h1);
		flush();
		check(40'(model.viol), 40'h0, "illegal packets seen");
		summarize();
	end

	// watchdog, well beyond the few tens of microseconds the sequence needs
	initial begin
		#2_000_000;
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end
endmodule
